/* File: rtl/spi_slave_port.sv */
`timescale 1ns/1ps
module spi_slave_port (
   input  wire logic        CLK_SYS,
   input  wire logic        SYS_RST,
   input  wire logic [31:0] SERIAL_GLOBAL_CONTROL_REG,
   input  wire logic [31:0] SERIAL_FORMAT_REG,
   input  wire logic        SERIAL_CLOCK_PIN,
   input  wire logic        SERIAL_IN_PIN,
   input  wire logic        CS_N_PIN,
   input  wire logic [15:0] TX_WORD,
   output logic             TX_TAKEN,
   output logic             SERIAL_OUT_PIN,
   output logic             SERIAL_OUT_OE,
   output logic [15:0]      RX_WORD,
   output logic             RX_VALID,
   output logic             CLOCK_TOO_FAST
);

   // ----------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------
   logic       slave_en;
   logic       phase;
   logic       pol;
   logic [7:0] ps;
   logic [8:0] min_cyc;

   // Slave only when the controller-select bit is clear.
   assign slave_en = ~SERIAL_GLOBAL_CONTROL_REG[spi_slave_pkg::CTRL_MASTER_BIT];
   assign phase    = SERIAL_FORMAT_REG[spi_slave_pkg::FMT_PHASE_BIT];
   assign pol      = SERIAL_FORMAT_REG[spi_slave_pkg::FMT_POL_BIT];
   assign ps       = SERIAL_FORMAT_REG[spi_slave_pkg::FMT_PS_MSB:spi_slave_pkg::FMT_PS_LSB];

   // Least clock period in bus cycles for the programmed prescale.
   function automatic logic [8:0] least_cycles(input logic [7:0] p);
      logic [8:0] c;
      c = (p == spi_slave_pkg::PS_ZERO) ? spi_slave_pkg::PS_ZERO_CYC
                                        : ({1'b0, p} + spi_slave_pkg::PER_ONE);
      if (c < 9'(spi_slave_pkg::MIN_PERIOD_CYC)) begin
         c = 9'(spi_slave_pkg::MIN_PERIOD_CYC);
      end
      return c;
   endfunction : least_cycles

   assign min_cyc = least_cycles(ps);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic sck_lvl;
   logic sck_rise;
   logic sck_fall;
   logic cs_lvl;
   logic cs_rise;
   logic cs_fall;
   logic mosi_lvl;

   spi_edge_sync u_sck (
      .CLK_SYS (CLK_SYS),
      .SYS_RST (SYS_RST),
      .pin_in  (SERIAL_CLOCK_PIN),
      .level   (sck_lvl),
      .rise    (sck_rise),
      .fall    (sck_fall)
   );

   spi_edge_sync #(.IDLE_LEVEL (spi_slave_pkg::CS_IDLE_LEVEL)) u_cs (
      .CLK_SYS (CLK_SYS),
      .SYS_RST (SYS_RST),
      .pin_in  (CS_N_PIN),
      .level   (cs_lvl),
      .rise    (cs_rise),
      .fall    (cs_fall)
   );

   // Data follows the same two-stage delay so it lines up with the clock edges.
   spi_edge_sync u_mosi (
      .CLK_SYS (CLK_SYS),
      .SYS_RST (SYS_RST),
      .pin_in  (SERIAL_IN_PIN),
      .level   (mosi_lvl),
      .rise    (),
      .fall    ()
   );

   // Edge roles: when polarity equals phase, launch on rise and sample on fall.
   logic same;
   logic launch_edge;
   logic sample_edge;
   assign same        = ~(pol ^ phase);
   assign launch_edge = same ? sck_rise : sck_fall;
   assign sample_edge = same ? sck_fall : sck_rise;

   // ----------------------------------------------------------------
   // Transfer state
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b01,
      ST_SHIFT = 2'b10
   } state_e;

   state_e      state_r,  state_nxt;
   logic [4:0]  cnt_r,    cnt_nxt;
   logic [15:0] rx_sh_r,  rx_sh_nxt;
   logic [15:0] tx_sh_r,  tx_sh_nxt;
   logic [15:0] rx_word_r, rx_word_nxt;
   logic        rx_vld_r, rx_vld_nxt;
   logic        taken_r,  taken_nxt;
   logic        so_r,     so_nxt;
   logic        oe_r,     oe_nxt;
   logic        first_r,  first_nxt;
   logic [8:0]  per_r,    per_nxt;
   logic        fast_r,   fast_nxt;

   // Framing, shifting and period check. A word is complete after its
   // sixteenth sample; a frame cut short drops the partial word.
   always_comb begin
      state_nxt   = state_r;
      cnt_nxt     = cnt_r;
      rx_sh_nxt   = rx_sh_r;
      tx_sh_nxt   = tx_sh_r;
      rx_word_nxt = rx_word_r;
      rx_vld_nxt  = 1'b0;
      taken_nxt   = 1'b0;
      so_nxt      = so_r;
      oe_nxt      = oe_r;
      first_nxt   = first_r;
      per_nxt     = (per_r == spi_slave_pkg::PER_MAX) ? per_r
                                                      : per_r + spi_slave_pkg::PER_ONE;
      fast_nxt    = fast_r;
      unique case (state_r)
         ST_IDLE: begin
            oe_nxt = 1'b0;
            if (cs_fall && slave_en) begin
               state_nxt = ST_SHIFT;
               cnt_nxt   = spi_slave_pkg::BIT_ZERO;
               tx_sh_nxt = TX_WORD;
               taken_nxt = 1'b1;
               so_nxt    = TX_WORD[spi_slave_pkg::WORD_BITS-1];
               oe_nxt    = 1'b1;
               first_nxt = 1'b1;
               fast_nxt  = 1'b0;
            end
         end
         ST_SHIFT: begin
            if (cs_lvl || !slave_en) begin
               state_nxt = ST_IDLE;
               oe_nxt    = 1'b0;
            end else begin
               // Period measured between successive sample edges.
               if (sample_edge) begin
                  per_nxt   = spi_slave_pkg::PER_ONE;
                  first_nxt = 1'b0;
                  if (!first_r && per_r < min_cyc) begin
                     fast_nxt = 1'b1;
                  end
                  rx_sh_nxt = {rx_sh_r[spi_slave_pkg::WORD_BITS-2:0], mosi_lvl};
                  cnt_nxt   = cnt_r + 5'h01;
                  if (cnt_r == spi_slave_pkg::LAST_BIT) begin
                     rx_word_nxt = {rx_sh_r[spi_slave_pkg::WORD_BITS-2:0], mosi_lvl};
                     rx_vld_nxt  = 1'b1;
                     state_nxt   = ST_IDLE;
                  end
               end
               // The top bit is on the line from chip select onwards. In phase 0
               // the first launch edge comes before any sample, so it must leave
               // that bit standing; only launches after a sample move to the next.
               if (launch_edge && cnt_r != spi_slave_pkg::BIT_ZERO) begin
                  tx_sh_nxt = {tx_sh_r[spi_slave_pkg::WORD_BITS-2:0], 1'b0};
                  so_nxt    = tx_sh_r[spi_slave_pkg::WORD_BITS-2];
               end
            end
         end
         default: begin
            state_nxt = ST_IDLE;
            oe_nxt    = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         state_r   <= ST_IDLE;
         cnt_r     <= spi_slave_pkg::BIT_ZERO;
         rx_sh_r   <= spi_slave_pkg::WORD_RESET;
         tx_sh_r   <= spi_slave_pkg::WORD_RESET;
         rx_word_r <= spi_slave_pkg::WORD_RESET;
         rx_vld_r  <= 1'b0;
         taken_r   <= 1'b0;
         so_r      <= 1'b0;
         oe_r      <= 1'b0;
         first_r   <= 1'b0;
         per_r     <= spi_slave_pkg::PER_ZERO;
         fast_r    <= 1'b0;
      end else begin
         state_r   <= state_nxt;
         cnt_r     <= cnt_nxt;
         rx_sh_r   <= rx_sh_nxt;
         tx_sh_r   <= tx_sh_nxt;
         rx_word_r <= rx_word_nxt;
         rx_vld_r  <= rx_vld_nxt;
         taken_r   <= taken_nxt;
         so_r      <= so_nxt;
         oe_r      <= oe_nxt;
         first_r   <= first_nxt;
         per_r     <= per_nxt;
         fast_r    <= fast_nxt;
      end
   end

   assign TX_TAKEN       = taken_r;
   assign SERIAL_OUT_PIN = so_r;
   assign SERIAL_OUT_OE  = oe_r;
   assign RX_WORD        = rx_word_r;
   assign RX_VALID       = rx_vld_r;
   assign CLOCK_TOO_FAST = fast_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);

   chk_master_idle: assert property (
      !slave_en |-> ##1 !SERIAL_OUT_OE ##1 !SERIAL_OUT_OE)
      else $error("Output enabled while in master mode.");
   chk_rx_after_sixteen: assert property (
      RX_VALID |-> $past(cnt_r) == spi_slave_pkg::LAST_BIT && $past(sample_edge))
      else $error("Word delivered without sixteenth sample.");
   chk_rx_pulse: assert property (
      RX_VALID |=> !RX_VALID)
      else $error("Receive valid longer than one cycle.");
   chk_sample_edge: assert property (
      (state_r == ST_SHIFT && !cs_lvl && slave_en && !sample_edge) |=> cnt_r == $past(cnt_r))
      else $error("Bit counted without a sample edge.");
   chk_launch_only: assert property (
      (state_r == ST_SHIFT && !launch_edge) |=> SERIAL_OUT_PIN == $past(SERIAL_OUT_PIN))
      else $error("Output changed away from a launch edge.");
   chk_phase_mode: assert property (
      (same && sck_fall && state_r == ST_SHIFT && !cs_lvl && slave_en) |=>
         rx_sh_r[0] == $past(mosi_lvl))
      else $error("Sample missed on the selected edge.");
   chk_pol_mode: assert property (
      (!same && sck_rise && state_r == ST_SHIFT && !cs_lvl && slave_en) |=>
         rx_sh_r[0] == $past(mosi_lvl))
      else $error("Sample missed on the polarity-selected edge.");
   chk_cs_ends: assert property (
      (state_r == ST_SHIFT && cs_lvl) |=> !SERIAL_OUT_OE ##0 state_r == ST_IDLE)
      else $error("Frame not ended by chip select.");
   chk_fast_flag: assert property (
      (state_r == ST_SHIFT && !cs_lvl && slave_en && sample_edge && !first_r
       && per_r < min_cyc) |=> CLOCK_TOO_FAST)
      else $error("Fast clock not flagged.");

   cov_word: cover property (RX_VALID);
   cov_mode3: cover property (pol && phase && RX_VALID);
   cov_abort: cover property (state_r == ST_SHIFT && cs_rise);
   cov_fast: cover property ($rose(CLOCK_TOO_FAST));

endmodule : spi_slave_port

/* File: rtl/spi_slave_pkg.sv */
// Notes on behaviour
// - Serial port acts as slave only while the controller-select bit 0 is clear.
// - Clock phase comes from format bit 16; clear is phase 0, set is phase 1.
// - Clock polarity bit 17 of the format register picks the active clock edge.
// - Serial clock period at least (prescale+1), or two, bus clocks, never under 25 ns.
// - Output changes after rising edge when polarity equals phase, else after falling.
// - Input sampled on falling edge when polarity equals phase, else on rising edge.
package spi_slave_pkg;

   // ----------------------------------------------------------------
   // Register field layout
   // ----------------------------------------------------------------
   localparam int unsigned CTRL_MASTER_BIT = 0;
   localparam int unsigned FMT_PHASE_BIT   = 16;
   localparam int unsigned FMT_POL_BIT     = 17;
   localparam int unsigned FMT_PS_LSB      = 8;
   localparam int unsigned FMT_PS_MSB      = 15;
   localparam int unsigned FMT_WIDTH       = 32;
   localparam int unsigned CTRL_WIDTH      = 32;

   // ----------------------------------------------------------------
   // Word and timing constants
   // ----------------------------------------------------------------
   localparam int unsigned WORD_BITS       = 16;
   localparam logic [4:0]  LAST_BIT        = 5'h0f;
   localparam logic [4:0]  BIT_ZERO        = 5'h00;
   localparam logic [15:0] WORD_RESET      = 16'h0000;
   localparam int unsigned MIN_PERIOD_NS   = 25;
   localparam int unsigned SYS_PERIOD_NS   = 100;
   // Least period rounds up, never below one cycle.
   localparam int unsigned MIN_PERIOD_CYC  =
      (MIN_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
   localparam logic [8:0]  PS_ZERO_CYC     = 9'h002;
   localparam logic [7:0]  PS_ZERO         = 8'h00;
   // Period counter limits; the counter saturates rather than wrapping.
   localparam logic [8:0]  PER_ZERO        = 9'h000;
   localparam logic [8:0]  PER_ONE         = 9'h001;
   localparam logic [8:0]  PER_MAX         = 9'h1ff;
   // Chip select rests high between frames.
   localparam logic        CS_IDLE_LEVEL   = 1'b1;

endpackage : spi_slave_pkg

/* File: rtl/spi_edge_sync.sv */
`timescale 1ns/1ps
module spi_edge_sync #(
   parameter logic IDLE_LEVEL = 1'b0
) (
   input  wire logic CLK_SYS,
   input  wire logic SYS_RST,
   input  wire logic pin_in,
   output logic      level,
   output logic      rise,
   output logic      fall
);

   logic meta_r;
   logic sync_r;
   logic last_r;
   logic meta_nxt;
   logic sync_nxt;
   logic last_nxt;

   // Two-stage synchroniser; only the second stage feeds the edge detect.
   always_comb begin
      meta_nxt = pin_in;
      sync_nxt = meta_r;
      last_nxt = sync_r;
   end

   // Stages reset to the pin's resting level, so that a pin already at
   // rest shows no false edge and a pin that leaves rest is still seen.
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         meta_r <= IDLE_LEVEL;
         sync_r <= IDLE_LEVEL;
         last_r <= IDLE_LEVEL;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
         last_r <= last_nxt;
      end
   end

   assign level = sync_r;
   assign rise  = sync_r & ~last_r;
   assign fall  = ~sync_r & last_r;

endmodule : spi_edge_sync

/* File: tb/spi_host_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host master model
// ----------------------------------------------------------------
module spi_host_model (
   input  wire logic clk_sys,
   input  wire logic miso,
   output logic      sclk,
   output logic      mosi,
   output logic      cs_n
);
   logic pol;
   logic pha;
   int   half;

   // Idle frame: clock parked at its idle level, chip select high.
   initial begin
      pol = 1'b0;
      pha = 1'b0;
      half = 6;
      sclk = 1'b0;
      mosi = 1'b1;
      cs_n = 1'b1;
   end

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask : wait_cyc

   // Sends bits of w MSB first; fewer than 16 bits aborts the word.
   task automatic xfer(input logic [15:0] w, input int bits, output logic [15:0] got);
      got = 16'h0000;
      sclk = pol;
      mosi = w[15];
      cs_n = 1'b0;
      wait_cyc(4 * half);
      for (int i = 0; i < bits; i++) begin
         // Data moves half a period away from the sample edge, so no race.
         if (pha) mosi = w[15 - i];
         wait_cyc(half);
         if (pha) got[15 - i] = miso;
         sclk = ~sclk;
         if (!pha) mosi = w[15 - i];
         wait_cyc(half);
         if (!pha) got[15 - i] = miso;
         sclk = ~sclk;
      end
      wait_cyc(half);
      cs_n = 1'b1;
      mosi = ~mosi;
      wait_cyc(4 * half);
   endtask : xfer
endmodule : spi_host_model

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   logic        clk_sys, sys_rst, sclk, mosi, cs_n, miso, oe, rx_valid, tx_taken, too_fast;
   logic [31:0] ctrl, fmt, seed;
   logic [15:0] tx_word, rx_word;
   logic        exp_fast;
   logic [15:0] exp_q[$];
   int          mismatches, comparisons, rx_cnt, tk_cnt, cycles;

   spi_slave_port DUT (
      .CLK_SYS                   (clk_sys),
      .SYS_RST                   (sys_rst),
      .SERIAL_GLOBAL_CONTROL_REG (ctrl),
      .SERIAL_FORMAT_REG         (fmt),
      .SERIAL_CLOCK_PIN          (sclk),
      .SERIAL_IN_PIN             (mosi),
      .CS_N_PIN                  (cs_n),
      .TX_WORD                   (tx_word),
      .TX_TAKEN                  (tx_taken),
      .SERIAL_OUT_PIN            (miso),
      .SERIAL_OUT_OE             (oe),
      .RX_WORD                   (rx_word),
      .RX_VALID                  (rx_valid),
      .CLOCK_TOO_FAST            (too_fast)
   );

   spi_host_model u_host (
      .clk_sys (clk_sys),
      .miso    (miso),
      .sclk    (sclk),
      .mosi    (mosi),
      .cs_n    (cs_n)
   );

   always #50 clk_sys = ~clk_sys;

   // ----------------------------------------------------------------
   // Shared helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : report_and_stop

   // One random word each way; the model queue holds what the port must deliver.
   task automatic word(input int bits, input logic rx_exp, input logic slave);
      logic [15:0] w, got;
      int          n_rx, n_tk;
      seed = xs(seed);
      w = seed[15:0];
      tx_word = seed[31:16];
      n_rx = rx_cnt;
      n_tk = tk_cnt;
      if (rx_exp) exp_q.push_back(w);
      u_host.xfer(w, bits, got);
      check("rx_count", rx_cnt - n_rx, {31'h0, rx_exp});
      check("taken_count", tk_cnt - n_tk, {31'h0, slave});
      if (rx_exp) check("host_word", {16'h0, got}, {16'h0, tx_word});
      check("oe_released", {31'h0, oe}, 32'h0);
   endtask : word

   // Pulse monitor: every delivered word is compared with the model at once.
   always @(posedge clk_sys) begin
      cycles++;
      if (tx_taken === 1'b1) tk_cnt++;
      if (rx_valid === 1'b1) begin
         rx_cnt++;
         check("rx_expected", exp_q.size() > 0, 32'h1);
         if (exp_q.size() > 0) check("rx_word", {16'h0, rx_word}, {16'h0, exp_q.pop_front()});
         check("too_fast", {31'h0, too_fast}, {31'h0, exp_fast});
         check("oe_at_word", {31'h0, oe}, 32'h1);
      end
      if (cycles == 20000) begin
         mismatches++;
         report_and_stop();
      end
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] ps;
      clk_sys = 1'b0;
      sys_rst = 1'b1;
      ctrl = 32'h00000000;
      fmt = 32'h00000000;
      tx_word = 16'h0000;
      seed = 32'h51e94bc6;
      exp_fast = 1'b0;
      repeat (20) @(posedge clk_sys);
      #2;
      sys_rst = 1'b0;
      check("oe_after_reset", {31'h0, oe}, 32'h0);
      // Let the pin synchronisers settle before the first frame starts.
      repeat (4) @(posedge clk_sys);
      #2;
      // Every polarity and phase pair, with prescale on and beside the period bound.
      for (int m = 0; m < 12; m++) begin
         seed = xs(seed);
         u_host.pol = m[0];
         u_host.pha = m[1];
         u_host.half = 6 + seed[1:0];
         ps = (m >= 8) ? 8'h00 : 8'(2 * u_host.half - 1 + m[2]);
         exp_fast = (m >= 4 && m < 8);
         fmt = {14'h0000, u_host.pol, u_host.pha, ps, 8'h00};
         word(16, 1'b1, 1'b1);
      end
      exp_fast = 1'b0;
      u_host.pol = 1'b1;
      u_host.pha = 1'b0;
      fmt = {14'h0000, u_host.pol, u_host.pha, 8'h03, 8'h00};
      word(9, 1'b0, 1'b1);
      word(16, 1'b1, 1'b1);
      ctrl = 32'h00000001;
      word(16, 1'b0, 1'b0);
      ctrl = 32'h00000000;
      word(16, 1'b1, 1'b1);
      check("queue_empty", exp_q.size(), 32'h0);
      report_and_stop();
   end
endmodule : tb_top
